//--- include/berl_params.svh
// Constants for the bus-error record logger: record fields and LIN codes.
// Assumes inclusion by its bare name from the package and berl_logger.
`ifndef BERL_PARAMS_SVH
`define BERL_PARAMS_SVH
`define BERL_ARB_ID         29'h0000000
`define BERL_TYPE_CAN_ERR   8'h06
`define BERL_TYPE_LIN_ERR   8'h15
`define BERL_LEN_4          4'h4
`define BERL_LEN_6          4'h6
`define BERL_LEN_7          4'h7
`define BERL_CODE_NO_RESP   16'h8400
`define BERL_CODE_SHORT     16'h8401
`define BERL_CODE_CS_BIT    16'hC008
`define BERL_CODE_CS_FRAME  16'hA008
`define BERL_CODE_RX_FRAME  16'hA010
`define BERL_CODE_ID_FRAME  16'hA020
`define BERL_CODE_ID_PAR    16'hC020
`define BERL_CODE_ID_TMO    16'h9020
`define BERL_CODE_SY_TMO    16'h9040
`define BERL_CODE_SY_BIT    16'hC040
`define BERL_CODE_SY_FRAME  16'hA040
`define BERL_CODE_TX_BIT    16'h4010
`define BERL_ST_ACTIVE      8'h00
`define BERL_ST_PASSIVE     8'h01
`define BERL_ST_BUSOFF      8'h02
`define BERL_FIFO_DEPTH     16
`define BERL_TS_W           32
`endif

//--- include/berl_pkg.sv
// Types shared by the bus-error record logger modules.
// Assumes berl_params.svh is on the include path.
`include "berl_params.svh"
package berl_pkg;
  // Communication state of the CAN controller
  typedef enum logic [1:0] {
    BERL_CAN_ACTIVE,
    BERL_CAN_PASSIVE,
    BERL_CAN_BUSOFF
  } berl_can_state_t;

  // Kind of LIN bus error reported by the LIN engine
  typedef enum logic [3:0] {
    BERL_LIN_NO_RESP,
    BERL_LIN_SHORT_RESP,
    BERL_LIN_CS_BIT,
    BERL_LIN_CS_FRAME,
    BERL_LIN_RX_FRAME,
    BERL_LIN_ID_FRAME,
    BERL_LIN_ID_PARITY,
    BERL_LIN_ID_TIMEOUT,
    BERL_LIN_SYNC_TIMEOUT,
    BERL_LIN_SYNC_BIT,
    BERL_LIN_SYNC_FRAME,
    BERL_LIN_TX_BIT
  } berl_lin_kind_t;

  // CAN error event as reported by the CAN engine
  typedef struct packed {
    berl_can_state_t state;
    logic [7:0]      tx_err_count;
    logic [7:0]      rx_err_count;
    logic [7:0]      err_capture;
  } berl_can_evt_t;

  // LIN error event as reported by the LIN engine
  typedef struct packed {
    berl_lin_kind_t kind;
    logic [2:0]     byte_index;
    logic [7:0]     observed;
    logic [7:0]     expected;
    logic [7:0]     frame_id;
  } berl_lin_evt_t;

  // One queue record
  typedef struct packed {
    logic [`BERL_TS_W-1:0] timestamp;
    logic [28:0]           arb_id;
    logic [7:0]            record_type_field;
    logic [3:0]            record_length_field;
    logic [63:0]           data;
  } berl_rec_t;
endpackage

//--- rtl/berl_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data is the head entry, read combinationally from storage.
`timescale 1ns/1ns
`default_nettype none
module berl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("berl_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire  logic       push;
  wire  logic       pop;
  wire  logic       full;
  wire  logic       empty;

  // Extra pointer bit tells full from empty
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) &&
                     (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Storage has no reset; only pointers carry state
  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  // Pointer update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- rtl/berl_timebase.sv
// Free-running timestamp counter.
// Assumes it counts every clock from reset release.
`timescale 1ns/1ns
`default_nettype none
module berl_timebase #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Time value
  output logic      [WIDTH-1:0] now
);
  initial begin
    if (WIDTH < 8)
      $error("berl_timebase: WIDTH too small");
  end

  // Wraps silently; readers compare with modular arithmetic
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      now <= '0;
    else
      now <= now + 1'b1;
  end
endmodule
`default_nettype wire

//--- rtl/berl_logger.sv
// Bus-error record logger: turns CAN and LIN error events into queue records.
// Assumes engines give one-cycle event pulses and a host drains the queue.
//
// Summary of operation
// - Logging disabled: no bus-error record enters the queue.
// - Logging enabled: one record per bus error; CAN wins a same-cycle tie, and a lost LIN or full-queue event sets dropped.
// - CAN record: timestamp, identifier 0, type 6, length 4.
// - CAN bytes: state, transmit count, receive count, capture register.
// - CAN state byte: active 0, passive 1, bus-off 2.
// - LIN timeouts, bit, framing and checksum errors each log a record.
// - LIN record: timestamp, identifier 0, type 21, length 4 to 7.
// - LIN bytes 0 and 1 carry error code, high byte first.
// - LIN bytes 2 and 3 are reserved; driven as zero.
// - Mismatch errors carry observed byte 4, expected byte 5.
// - Errors after the header carry the frame identifier in byte 6.
// - No response 8400, short response 8401, length 7, identifier.
// - Checksum bit C008 with bytes; checksum framing A008, bytes zero.
// - Data byte n framing A010 plus n, length 7, identifier.
// - Identifier framing A020, parity C020, length 6, with bytes.
// - Identifier timeout 9020, sync timeout 9040, length 4.
// - Sync bit C040 length 6 with bytes; sync framing A040 length 4.
// - Slave readback bit error on byte n: 4010 plus n, length 7.
`timescale 1ns/1ns
`default_nettype none
`include "berl_params.svh"
module berl_logger
  import berl_pkg::*;
#(
  parameter int DEPTH = `BERL_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Configuration
  input  wire logic          log_bus_errors,
  input  wire logic          start,
  // CAN engine
  input  wire logic          can_err,
  input  wire berl_can_evt_t can_evt,
  // LIN engine
  input  wire logic          lin_err,
  input  wire berl_lin_evt_t lin_evt,
  // Receive queue
  output logic               rec_valid,
  input  wire logic          rec_ready,
  output berl_rec_t          rec_data,
  // Status
  output logic               running,
  output logic               dropped
);
  localparam int RW = $bits(berl_rec_t);

  initial begin
    if (DEPTH < 2)
      $error("berl_logger: DEPTH must be at least 2");
  end

  logic                  enabled;
  logic                  stage_valid;
  berl_rec_t             stage;
  logic                  out_v;
  berl_rec_t             out_d;
  wire  logic [`BERL_TS_W-1:0] now;
  wire  logic            fifo_ready;
  wire  logic            fifo_out_valid;
  wire  berl_rec_t       fifo_out_data;
  wire  logic            accept_can;
  wire  logic            accept_lin;
  wire  logic            stage_free;
  wire  berl_rec_t       can_rec;
  wire  berl_rec_t       lin_rec;
  wire  logic            stage_push;
  wire  logic            out_free;

  // Timestamp source shared by both engines
  berl_timebase #(
    .WIDTH (`BERL_TS_W)
  ) u_time (
    .clk (clk),
    .rst (rst),
    .now (now)
  );

  // State byte encoding
  function automatic logic [7:0] can_state_byte(berl_can_state_t s);
    case (s)
      BERL_CAN_ACTIVE:  return `BERL_ST_ACTIVE;
      BERL_CAN_PASSIVE: return `BERL_ST_PASSIVE;
      BERL_CAN_BUSOFF:  return `BERL_ST_BUSOFF;
      default:          return `BERL_ST_BUSOFF;
    endcase
  endfunction

  // Error code per kind; indexed codes add the byte number
  function automatic logic [15:0] lin_code(berl_lin_evt_t e);
    case (e.kind)
      BERL_LIN_NO_RESP:      return `BERL_CODE_NO_RESP;
      BERL_LIN_SHORT_RESP:   return `BERL_CODE_SHORT;
      BERL_LIN_CS_BIT:       return `BERL_CODE_CS_BIT;
      BERL_LIN_CS_FRAME:     return `BERL_CODE_CS_FRAME;
      BERL_LIN_RX_FRAME:     return `BERL_CODE_RX_FRAME +
                                    {13'h0000, e.byte_index};
      BERL_LIN_ID_FRAME:     return `BERL_CODE_ID_FRAME;
      BERL_LIN_ID_PARITY:    return `BERL_CODE_ID_PAR;
      BERL_LIN_ID_TIMEOUT:   return `BERL_CODE_ID_TMO;
      BERL_LIN_SYNC_TIMEOUT: return `BERL_CODE_SY_TMO;
      BERL_LIN_SYNC_BIT:     return `BERL_CODE_SY_BIT;
      BERL_LIN_SYNC_FRAME:   return `BERL_CODE_SY_FRAME;
      BERL_LIN_TX_BIT:       return `BERL_CODE_TX_BIT +
                                    {13'h0000, e.byte_index};
      default:               return `BERL_CODE_NO_RESP;
    endcase
  endfunction

  // Record length per kind
  function automatic logic [3:0] lin_len(berl_lin_kind_t k);
    case (k)
      BERL_LIN_ID_FRAME, BERL_LIN_ID_PARITY,
      BERL_LIN_SYNC_BIT:     return `BERL_LEN_6;
      BERL_LIN_ID_TIMEOUT, BERL_LIN_SYNC_TIMEOUT,
      BERL_LIN_SYNC_FRAME:   return `BERL_LEN_4;
      default:               return `BERL_LEN_7;
    endcase
  endfunction

  // Kinds that carry observed and expected bytes
  function automatic logic lin_has_bytes(berl_lin_kind_t k);
    case (k)
      BERL_LIN_CS_BIT, BERL_LIN_ID_FRAME, BERL_LIN_ID_PARITY,
      BERL_LIN_SYNC_BIT, BERL_LIN_TX_BIT: return 1'b1;
      default:                            return 1'b0;
    endcase
  endfunction

  // Record assembly; unused bytes are zero rather than left floating
  assign can_rec.timestamp           = now;
  assign can_rec.arb_id              = `BERL_ARB_ID;
  assign can_rec.record_type_field   = `BERL_TYPE_CAN_ERR;
  assign can_rec.record_length_field = `BERL_LEN_4;
  assign can_rec.data = {can_state_byte(can_evt.state),
                         can_evt.tx_err_count,
                         can_evt.rx_err_count,
                         can_evt.err_capture,
                         32'h00000000};

  assign lin_rec.timestamp           = now;
  assign lin_rec.arb_id              = `BERL_ARB_ID;
  assign lin_rec.record_type_field   = `BERL_TYPE_LIN_ERR;
  assign lin_rec.record_length_field = lin_len(lin_evt.kind);
  assign lin_rec.data = {lin_code(lin_evt),
                         16'h0000,
                         lin_has_bytes(lin_evt.kind) ?
                           lin_evt.observed : 8'h00,
                         lin_has_bytes(lin_evt.kind) ?
                           lin_evt.expected : 8'h00,
                         (lin_len(lin_evt.kind) == `BERL_LEN_7) ?
                           lin_evt.frame_id : 8'h00,
                         8'h00};

  // Acceptance: CAN first if both fire in one cycle, LIN dropped and flagged
  assign stage_free = !stage_valid || fifo_ready;
  assign accept_can = enabled && can_err;
  assign accept_lin = enabled && lin_err;
  assign stage_push = stage_free && (accept_can || accept_lin);
  assign out_free   = !out_v || rec_ready;

  // Setting is latched at start; later changes do nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      enabled <= 1'b0;
    end else if (start && !running) begin
      running <= 1'b1;
      enabled <= log_bus_errors;
    end
  end

  // One-deep staging ahead of the queue keeps detection cycle timing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_valid <= 1'b0;
      stage       <= '0;
      dropped     <= 1'b0;
    end else begin
      if (stage_push) begin
        stage_valid <= 1'b1;
        stage       <= accept_can ? can_rec : lin_rec;
      end else if (fifo_ready)
        stage_valid <= 1'b0;
      // A queue too full to take a record is flagged, not hidden
      if ((accept_can || accept_lin) && !stage_free)
        dropped <= 1'b1;
      else if (accept_can && accept_lin)
        dropped <= 1'b1;
    end
  end

  berl_fifo #(
    .WIDTH (RW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (stage_valid),
    .in_ready  (fifo_ready),
    .in_data   (stage),
    .out_valid (fifo_out_valid),
    .out_ready (out_free),
    .out_data  (fifo_out_data)
  );

  // Output register so queue ports come from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_v <= 1'b0;
      out_d <= '0;
    end else if (out_free) begin
      out_v <= fifo_out_valid;
      out_d <= fifo_out_data;
    end
  end

  assign rec_valid = out_v;
  assign rec_data  = out_d;

  // Checks the stage and the output register: nothing staged or offered while logging is off
  property p_disabled_quiet;
    @(posedge clk) disable iff (rst)
      !enabled |-> !stage_valid && !rec_valid;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("record staged while logging disabled");

  property p_can_staged;
    @(posedge clk) disable iff (rst)
      accept_can && stage_free |=> stage_valid &&
        stage.record_type_field == 8'h06 &&
        stage.record_length_field == 4'h4;
  endproperty
  a_can_staged: assert property (p_can_staged)
    else $error("CAN record not staged with type 6 length 4");

  property p_stamp;
    @(posedge clk) disable iff (rst)
      stage_push |=> stage.timestamp == $past(now);
  endproperty
  a_stamp: assert property (p_stamp)
    else $error("timestamp not from detection cycle");

  property p_lin_type;
    @(posedge clk) disable iff (rst)
      accept_lin && !accept_can && stage_free |=>
        stage.record_type_field == 8'h15 && stage.arb_id == 29'h0;
  endproperty
  a_lin_type: assert property (p_lin_type)
    else $error("LIN record type not 21");

  property p_state_enc;
    @(posedge clk) disable iff (rst)
      can_evt.state == BERL_CAN_PASSIVE |-> can_rec.data[63:56] == 8'h01;
  endproperty
  a_state_enc: assert property (p_state_enc)
    else $error("passive state not encoded as 1");

  property p_rxframe_code;
    @(posedge clk) disable iff (rst)
      lin_evt.kind == BERL_LIN_RX_FRAME |->
        lin_rec.data[63:48] == 16'hA010 + lin_evt.byte_index &&
        lin_rec.record_length_field == 4'h7;
  endproperty
  a_rxframe_code: assert property (p_rxframe_code)
    else $error("data framing code wrong");

  property p_sync_tmo;
    @(posedge clk) disable iff (rst)
      lin_evt.kind == BERL_LIN_SYNC_TIMEOUT |->
        lin_rec.data[63:48] == 16'h9040 &&
        lin_rec.record_length_field == 4'h4;
  endproperty
  a_sync_tmo: assert property (p_sync_tmo)
    else $error("sync timeout code wrong");

  property p_cs_frame_zero;
    @(posedge clk) disable iff (rst)
      lin_evt.kind == BERL_LIN_CS_FRAME |->
        lin_rec.data[31:16] == 16'h0000 &&
        lin_rec.data[63:48] == 16'hA008;
  endproperty
  a_cs_frame_zero: assert property (p_cs_frame_zero)
    else $error("checksum framing bytes not zero");

  property p_enable_frozen;
    @(posedge clk) disable iff (rst)
      running |=> $stable(enabled);
  endproperty
  a_enable_frozen: assert property (p_enable_frozen)
    else $error("logging setting changed after start");

  c_can_rec: cover property (@(posedge clk) disable iff (rst)
    accept_can ##[1:20] rec_valid && rec_ready);
  c_lin_rec: cover property (@(posedge clk) disable iff (rst)
    accept_lin ##[1:20] rec_valid && rec_ready);
  c_full: cover property (@(posedge clk) disable iff (rst) !fifo_ready);
endmodule
`default_nettype wire

//--- tb/berl_host_model.sv
// Host model: drains the receive queue of records, stalls on command.
// Assumes records are offered with valid and ready on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module berl_host_model
  import berl_pkg::*;
(
  // Clock
  input  wire logic      clk,
  // Queue side
  input  wire logic      rec_valid,
  output logic           rec_ready,
  input  wire berl_rec_t rec_data,
  // Bench control
  input  wire logic      stall
);
  berl_rec_t recs[$];
  // Ready moves off the sampling edge so the take edge is unambiguous
  initial begin
    rec_ready = 1'b0;
    forever @(negedge clk) rec_ready <= !stall;
  end
  // A record is taken only at an edge where valid and ready are both high
  always @(posedge clk) begin
    if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
      recs.push_back(rec_data);
    end
  end
endmodule
`default_nettype wire

//--- tb/berl_logger_tb_top.sv
// Bench for the bus-error record logger: gating, CAN and LIN records, fill.
// Assumes the host model drains the queue; inputs change on falling edges.
`timescale 1ns/1ns
`default_nettype none
module berl_logger_tb_top;
  import berl_pkg::*;
  logic          clk;
  logic          rst;
  logic          log_bus_errors;
  logic          start;
  logic          can_err;
  berl_can_evt_t can_evt;
  logic          lin_err;
  berl_lin_evt_t lin_evt;
  logic          rec_valid;
  logic          rec_ready;
  berl_rec_t     rec_data;
  logic          running;
  logic          dropped;
  logic          stall;
  int            bad_count;
  int            total_checks;
  // Expected LIN code, length and which optional bytes are filled, by kind
  localparam logic [15:0] CODE [12] = '{16'h8400, 16'h8401, 16'hC008,
    16'hA008, 16'hA010, 16'hA020, 16'hC020, 16'h9020, 16'h9040, 16'hC040,
    16'hA040, 16'h4010};
  localparam logic [3:0] LEN [12] = '{4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h6,
    4'h6, 4'h4, 4'h4, 4'h6, 4'h4, 4'h7};
  localparam logic [11:0] HAS_B  = 12'hA64;
  localparam logic [11:0] HAS_ID = 12'h81F;

  berl_logger #(.DEPTH(16)) uut (
    .clk(clk), .rst(rst), .log_bus_errors(log_bus_errors), .start(start),
    .can_err(can_err), .can_evt(can_evt), .lin_err(lin_err),
    .lin_evt(lin_evt), .rec_valid(rec_valid), .rec_ready(rec_ready),
    .rec_data(rec_data), .running(running), .dropped(dropped));
  berl_host_model host (
    .clk(clk), .rec_valid(rec_valid), .rec_ready(rec_ready),
    .rec_data(rec_data), .stall(stall));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(negedge clk);
  endtask

  // Bounded wait for the host to hold n records
  task automatic wait_recs(input int n);
    int i;
    for (i = 0; i < 300 && host.recs.size() < n; i++) tick;
    if (host.recs.size() < n) begin
      chk(host.recs.size(), n);
      results;
    end
  endtask

  task automatic do_reset;
    rst = 1'b1;
    repeat (16) tick;
    rst = 1'b0;
    tick;
  endtask

  // Setting is placed before start; start is held for one cycle
  task automatic do_start(input logic en);
    log_bus_errors = en;
    start = 1'b1;
    tick;
    start = 1'b0;
    tick;
  endtask

  // Raise an event for one cycle; the caller lowers the strobe at the end
  task automatic can_send(input int s, input logic [7:0] tx);
    can_err = 1'b1;
    can_evt = '{berl_can_state_t'(s), tx, 8'h20 + tx, 8'h30 + tx};
    tick;
  endtask

  task automatic lin_send(input int k, input logic [2:0] n);
    lin_err = 1'b1;
    lin_evt = '{berl_lin_kind_t'(k), n, 8'h50 + k, 8'hA0 + k, 8'h3C};
    tick;
  endtask

  // Events before start, with the setting off, or changed late, are lost
  task automatic t_gate;
    log_bus_errors = 1'b1;
    can_send(0, 8'h01);
    can_err = 1'b0;
    repeat (6) tick;
    do_start(1'b0);
    chk(running, 1'b1);
    can_send(1, 8'h02);
    can_err = 1'b0;
    lin_send(0, 3'h0);
    lin_err = 1'b0;
    do_start(1'b1);
    can_send(2, 8'h03);
    can_err = 1'b0;
    repeat (12) tick;
    chk(host.recs.size(), 0);
    chk(rec_valid, 1'b0);
    $display("test gate done");
  endtask

  // Back-to-back CAN errors in every state
  task automatic t_can;
    int i;
    berl_rec_t r;
    logic [31:0] e;
    do_reset;
    do_start(1'b1);
    for (i = 0; i < 3; i++) can_send(i, 8'h10 + i);
    can_err = 1'b0;
    wait_recs(3);
    for (i = 0; i < 3; i++) begin
      r = host.recs[i];
      chk(r.arb_id, 29'h0);
      chk(r.record_type_field, 8'h06);
      chk(r.record_length_field, 4'h4);
      e = {8'(i), 8'(8'h10 + i), 8'(8'h30 + i), 8'(8'h40 + i)};
      chk(r.data[63:32], e);
      chk(r.timestamp - host.recs[0].timestamp, i);
    end
    chk(host.recs.size(), 3);
    chk(dropped, 1'b0);
    $display("test can done");
  endtask

  // Every LIN error kind back to back, data framing at byte index 7, the others at 5
  task automatic t_lin;
    int k;
    int b;
    logic [63:0] m;
    logic [63:0] e;
    logic [2:0] n;
    berl_rec_t r;
    host.recs.delete();
    for (k = 0; k < 12; k++) lin_send(k, (k == 4) ? 3'h7 : 3'h5);
    lin_err = 1'b0;
    wait_recs(12);
    for (k = 0; k < 12; k++) begin
      r = host.recs[k];
      n = (k == 4) ? 3'h7 : 3'h5;
      e = {CODE[k] + ((k == 4 || k == 11) ? n : 3'h0), 16'h0000,
           HAS_B[k] ? {8'(8'h50 + k), 8'(8'hA0 + k)} : 16'h0000,
           HAS_ID[k] ? 8'h3C : 8'h00, 8'h00};
      // Reserved bytes 2 and 3 and bytes past the length are ignored
      m = 64'hFFFF_0000_0000_0000;
      for (b = 4; b < 7; b++) if (b < LEN[k]) m[63-8*b -: 8] = 8'hFF;
      chk(r.record_type_field, 8'h15);
      chk(r.arb_id, 29'h0);
      chk(r.record_length_field, LEN[k]);
      chk(r.data[63:48],
          e[63:48]);
      chk(r.data[31:0] & m[31:0], e[31:0] & m[31:0]);
      chk(r.timestamp - host.recs[0].timestamp, k);
    end
    $display("test lin done");
  endtask

  // Stalled host: queue fills, later events drop, order is kept
  task automatic t_fill;
    int i;
    berl_rec_t d;
    host.recs.delete();
    stall = 1'b1;
    repeat (2) tick;
    for (i = 0; i < 24; i++) can_send(0, i);
    can_err = 1'b0;
    repeat (4) tick;
    chk(dropped, 1'b1);
    chk(rec_valid, 1'b1);
    d = rec_data;
    repeat (3) tick;
    chk(rec_data[63:0], d[63:0]);
    stall = 1'b0;
    wait_recs(16);
    for (i = 0; i < 40 && rec_valid === 1'b1; i++) tick;
    // A queue that never drains counts as a mismatch
    if (rec_valid !== 1'b0) chk(rec_valid, 1'b0);
    chk(host.recs.size() >= 16 && host.recs.size() < 24, 1'b1);
    for (i = 0; i < host.recs.size(); i++) begin
      chk(host.recs[i].data[55:48], i);
    end
    $display("test fill done");
  endtask

  // CAN and LIN in one cycle: the CAN record is kept, LIN is lost and flagged
  task automatic t_tie;
    berl_rec_t r;
    do_reset;
    do_start(1'b1);
    host.recs.delete();
    chk(dropped, 1'b0);
    lin_err = 1'b1;
    lin_evt = '{BERL_LIN_NO_RESP, 3'h0, 8'h00, 8'h00, 8'h3C};
    can_send(1, 8'h77);
    can_err = 1'b0;
    lin_err = 1'b0;
    wait_recs(1);
    repeat (8) tick;
    r = host.recs[0];
    chk(host.recs.size(), 1);
    chk(r.record_type_field, 8'h06);
    chk(r.data[55:48], 8'h77);
    chk(dropped, 1'b1);
    $display("test tie done");
  endtask

  initial begin
    bad_count = 0;
    total_checks = 0;
    rst = 1'b1;
    log_bus_errors = 1'b0;
    start = 1'b0;
    can_err = 1'b0;
    can_evt = '0;
    lin_err = 1'b0;
    lin_evt = '0;
    stall = 1'b0;
    do_reset;
    t_gate;
    t_can;
    t_lin;
    t_fill;
    t_tie;
    results;
  end
endmodule
`default_nettype wire
